// ### rtl/fet_ctrl.sv
/*
  Overheat diode emulation, temperature PWM encoder and drive strength
  selector of an integrated power FET driver.
  Assumes comparator levels synchronous to clk and a decoded select pin class.
*/
// Functional notes
// - Select pin grounded gives 150 V/ns
// - Select pin on regulator gives 100 V/ns
// - Regulator strap tested once, then locked
// - Resistor maps to 20 to 150 V/ns
// - Otherwise filtered sampling updates slew continuously
// - Temperature PWM near 9 kHz, refreshed per period
// - Duty floor about one percent below 25 C
// - Duty three to 82 percent, 25-150 C
// - Slope continues above 150 C until trip
// - Overheat holds temperature output high
// - Gate falling edge forces state 1
// - State 1 blanks then enters state 2
// - Overheat entry state is state 2
// - Negative drain voltage moves to state 3
// - State 3 conducts until first-quadrant current
// - Without gate activity, alternate states 2, 3
// - Fault asserted in overheat, released after cooling
// - Driver overheat disables emulation, FET off
`timescale 1ns/1ps
`include "fet_ctrl_regs.svh"

module fet_ctrl #(
  parameter int PWM_PERIOD = `PWM_PERIOD_CYC,  // Cycles per PWM period
  parameter int SEL_FILT   = `SEL_FILT_CYC     // Select pin filter cycles
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 gate_cmd,     // Gate command from controller
  input  wire fet_ctrl_pkg::sense_t sense,        // Comparator levels
  input  wire logic [1:0]           sel_class,    // Select pin class
  input  wire logic [2:0]           sel_res_code, // Resistor slew code
  output logic                      fet_on,       // Gate drive request
  output logic                      temp_out,     // Temperature PWM
  output logic                      fault_n,      // Fault, active low
  output logic [2:0]                slew_code     // Turn-on slew setting
);

  // Reset release synchroniser
  logic rst_meta;
  logic rst_n;

  // State and next state
  fet_ctrl_pkg::state_t s_reg;
  fet_ctrl_pkg::state_t s_next;

  // Map a temperature code to PWM high time in cycles
  function automatic logic [15:0] duty_of(input logic [7:0] t);
    int pm;
    if (t < 8'(`TEMP_LOW_C)) begin
      pm = `DUTY_FLOOR_PM;  // Floor keeps edges visible to the reader
    end else begin
      pm = `DUTY_LOW_PM + (int'(t) - `TEMP_LOW_C) * (`DUTY_HIGH_PM - `DUTY_LOW_PM)
           / (`TEMP_HIGH_C - `TEMP_LOW_C);
      if (pm > 999) begin
        pm = 999;  // Never a full-high PWM, that means fault
      end
    end
    duty_of = 16'(pm * PWM_PERIOD / 1000);
  endfunction

  // Two-flop reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Next state of all block logic
  always_comb begin
    logic fall;
    logic hot_any;
    logic [2:0] want;
    fall    = 1'b0;
    hot_any = 1'b0;
    want    = 3'h0;
    s_next  = s_reg;
    s_next.gate_d = gate_cmd;
    fall    = s_reg.gate_d && !gate_cmd;
    hot_any = sense.fet_hot || sense.drv_hot;

    // Fault output follows either overheat
    s_next.fault_n = !hot_any;

    // Diode emulation machine
    if (sense.drv_hot) begin
      s_next.idm    = fet_ctrl_pkg::IDM_OFF;
      s_next.fet_on = 1'b0;
    end else if (!sense.fet_hot) begin
      s_next.idm    = fet_ctrl_pkg::IDM_OFF;
      s_next.fet_on = gate_cmd;               // Normal switching
    end else if (fall) begin
      s_next.idm       = fet_ctrl_pkg::IDM_BLANK;
      s_next.blank_cnt = '0;
      s_next.fet_on    = 1'b0;
    end else begin
      case (s_reg.idm)
        fet_ctrl_pkg::IDM_OFF: begin
          s_next.idm    = fet_ctrl_pkg::IDM_WATCH;
          s_next.fet_on = 1'b0;
        end
        fet_ctrl_pkg::IDM_BLANK: begin
          s_next.fet_on = 1'b0;
          // Fixed wait, no drain check, cannot stick
          if (s_reg.blank_cnt >= 8'(`BLANK_CYC - 1)) begin
            s_next.idm = fet_ctrl_pkg::IDM_WATCH;
          end else begin
            s_next.blank_cnt = s_reg.blank_cnt + 8'h01;
          end
        end
        fet_ctrl_pkg::IDM_WATCH: begin
          // Gate rising edge has no effect here
          s_next.fet_on = 1'b0;
          if (sense.drain_neg) begin
            s_next.idm    = fet_ctrl_pkg::IDM_COND;
            s_next.fet_on = 1'b1;
          end
        end
        fet_ctrl_pkg::IDM_COND: begin
          s_next.fet_on = 1'b1;
          if (sense.curr_q1) begin
            s_next.idm    = fet_ctrl_pkg::IDM_WATCH;
            s_next.fet_on = 1'b0;
          end
        end
        default: begin
          s_next.idm    = fet_ctrl_pkg::IDM_WATCH;
          s_next.fet_on = 1'b0;
        end
      endcase
    end

    // Temperature PWM, duty latched at each period start
    if (s_reg.pwm_cnt >= 16'(PWM_PERIOD - 1)) begin
      s_next.pwm_cnt  = '0;
      s_next.duty_cyc = duty_of(sense.temp_c);
    end else begin
      s_next.pwm_cnt = s_reg.pwm_cnt + 16'h0001;
    end
    if (sense.fet_hot) begin
      s_next.temp_out = 1'b1;
    end else begin
      s_next.temp_out = (s_next.pwm_cnt < s_next.duty_cyc);
    end

    // Drive strength select
    case (sel_class)
      `SEL_GND: want = `SLEW_CODE_FAST;
      `SEL_REG: want = `SLEW_CODE_100;
      default:  want = sel_res_code;
    endcase
    if (!s_reg.strap_done) begin
      // One-time strap test just after reset release
      s_next.strap_done   = 1'b1;
      s_next.strap_locked = (sel_class == `SEL_REG);
      s_next.slew         = want;
      s_next.slew_cand    = want;
    end else if (!s_reg.strap_locked) begin
      // Heavy filter: value must hold steady the whole window
      if (want != s_reg.slew_cand) begin
        s_next.slew_cand = want;
        s_next.filt_cnt  = '0;
      end else if (s_reg.filt_cnt >= 13'(SEL_FILT - 1)) begin
        s_next.slew     = s_reg.slew_cand;
        s_next.filt_cnt = '0;
      end else begin
        s_next.filt_cnt = s_reg.filt_cnt + 13'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{idm: fet_ctrl_pkg::IDM_OFF, gate_d: 1'b0, blank_cnt: 8'h00,
                 pwm_cnt: 16'h0000, duty_cyc: 16'h0000, temp_out: 1'b0,
                 fault_n: 1'b0, fet_on: 1'b0, strap_done: 1'b0,
                 strap_locked: 1'b0, slew: 3'h0, slew_cand: 3'h0,
                 filt_cnt: 13'h0000};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign fet_on    = s_reg.fet_on;
  assign temp_out  = s_reg.temp_out;
  assign fault_n   = s_reg.fault_n;
  assign slew_code = s_reg.slew;

  // Assertions
  a_fall_to_blank: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.gate_d && !gate_cmd && sense.fet_hot && !sense.drv_hot)
      |=> (s_reg.idm == fet_ctrl_pkg::IDM_BLANK && !fet_on))
    else $error("falling edge did not force state 1");

  a_blank_exit: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.idm == fet_ctrl_pkg::IDM_BLANK) |-> ##[1:60]
      (s_reg.idm != fet_ctrl_pkg::IDM_BLANK))
    else $error("blanking did not end");

  a_entry_watch: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.idm == fet_ctrl_pkg::IDM_OFF && sense.fet_hot && !sense.drv_hot
     && !(s_reg.gate_d && !gate_cmd)) |=> (s_reg.idm == fet_ctrl_pkg::IDM_WATCH))
    else $error("overheat entry not state 2");

  a_neg_to_cond: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.idm == fet_ctrl_pkg::IDM_WATCH && sense.drain_neg && sense.fet_hot
     && !sense.drv_hot && !(s_reg.gate_d && !gate_cmd)) |=> fet_on)
    else $error("negative drain did not turn fet on");

  a_q1_off: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.idm == fet_ctrl_pkg::IDM_COND && sense.curr_q1 && sense.fet_hot
     && !sense.drv_hot) |=> !fet_on)
    else $error("first-quadrant current left fet on");

  a_watch_off: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.idm == fet_ctrl_pkg::IDM_WATCH && !sense.drain_neg && sense.fet_hot)
      |=> !fet_on)
    else $error("state 2 turned fet on from gate");

  a_drv_hot_off: assert property (@(posedge clk) disable iff (!rst_n)
    sense.drv_hot |=> (!fet_on && !fault_n))
    else $error("driver overheat left fet on");

  a_temp_high: assert property (@(posedge clk) disable iff (!rst_n)
    sense.fet_hot |=> temp_out)
    else $error("temp output not high in overheat");

  a_strap_lock: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.strap_locked && s_reg.strap_done) |=> $stable(slew_code))
    else $error("locked slew setting changed");

  a_fault_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (!sense.fet_hot && !sense.drv_hot) |=> fault_n)
    else $error("fault not released after cooling");

  // The checks below restate the rules from the header constants where they
  // can, so that a wrong constant or a slip in the next-state logic shows up
  // as a firing check rather than as a quietly shifted output. Each one is
  // guarded by the internal reset copy, never by the raw pin, so the two
  // cycles of release do not produce false hits.

  // Normal switching: fet follows the gate command one cycle late
  a_gate_follow: assert property (@(posedge clk) disable iff (!rst_n)
    (!sense.fet_hot && !sense.drv_hot) |=> (fet_on == $past(gate_cmd)))
    else $error("fet did not follow gate without overheat");

  // Blanking always holds the fet off, whatever the drain does
  a_blank_fet_off: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.idm == fet_ctrl_pkg::IDM_BLANK) |-> !fet_on)
    else $error("fet on during blanking");

  // Blanking lasts its full count unless cooling or driver overheat intervenes; a new edge restarts it
  a_blank_length: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.idm == fet_ctrl_pkg::IDM_BLANK && s_reg.blank_cnt < 8'(`BLANK_CYC - 1)
     && sense.fet_hot && !sense.drv_hot) |=> (s_reg.idm == fet_ctrl_pkg::IDM_BLANK))
    else $error("blanking ended early");

  // With no falling edge the machine only swaps between states 2 and 3
  a_idle_two_states: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.idm == fet_ctrl_pkg::IDM_WATCH && sense.fet_hot && !sense.drv_hot
     && !(s_reg.gate_d && !gate_cmd))
      |=> (s_reg.idm == fet_ctrl_pkg::IDM_WATCH || s_reg.idm == fet_ctrl_pkg::IDM_COND))
    else $error("idle machine left states 2 and 3");

  // Driver overheat parks the machine outside emulation
  a_drv_hot_idle: assert property (@(posedge clk) disable iff (!rst_n)
    sense.drv_hot |=> (s_reg.idm == fet_ctrl_pkg::IDM_OFF))
    else $error("emulation active in driver overheat");

  // Strap test on a grounded pin picks the fastest code
  a_ground_slew: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_reg.strap_done && sel_class == `SEL_GND) |=> (slew_code == `SLEW_CODE_FAST))
    else $error("grounded select pin not fastest slew");

  // Strap test on the regulator picks the fixed middle code and locks
  a_reg_slew: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_reg.strap_done && sel_class == `SEL_REG)
      |=> (slew_code == `SLEW_CODE_100 && s_reg.strap_locked))
    else $error("regulator strap not locked to 100 V/ns code");

  // Strap test on a resistor takes the resistor code as it stands
  a_res_slew: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_reg.strap_done && sel_class != `SEL_GND && sel_class != `SEL_REG)
      |=> (slew_code == $past(sel_res_code)))
    else $error("resistor code not taken at strap test");

  // The filter lets nothing through before its window has run out
  a_filter_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.strap_done && s_reg.filt_cnt < 13'(SEL_FILT - 1)) |=> $stable(slew_code))
    else $error("slew changed inside filter window");

  // Duty is only relatched at the period wrap
  a_duty_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.pwm_cnt != 16'(PWM_PERIOD - 1)) |=> $stable(s_reg.duty_cyc))
    else $error("duty changed inside a period");

  // Outside overheat the pin is the plain compare of count and duty
  a_temp_pwm: assert property (@(posedge clk) disable iff (!rst_n)
    (!sense.fet_hot) |=> (temp_out == (s_reg.pwm_cnt < s_reg.duty_cyc)))
    else $error("temp output not the pwm compare");

  // Cold die gives the floor duty, worked from the constants
  a_duty_floor: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.pwm_cnt == 16'(PWM_PERIOD - 1) && sense.temp_c < 8'(`TEMP_LOW_C))
      |=> (s_reg.duty_cyc == 16'(`DUTY_FLOOR_PM * PWM_PERIOD / 1000)))
    else $error("cold die duty not at floor");

  // Main scenarios worth seeing at least once
  c_idm_cycle: cover property (@(posedge clk) disable iff (!rst_n)
    s_reg.idm == fet_ctrl_pkg::IDM_WATCH ##1 s_reg.idm == fet_ctrl_pkg::IDM_COND);
  c_blank: cover property (@(posedge clk) disable iff (!rst_n)
    s_reg.idm == fet_ctrl_pkg::IDM_BLANK ##1 s_reg.idm == fet_ctrl_pkg::IDM_WATCH);
  c_slew_update: cover property (@(posedge clk) disable iff (!rst_n)
    !$stable(slew_code) && s_reg.strap_done);
  c_temp_rise: cover property (@(posedge clk) disable iff (!rst_n) $rose(temp_out));
  c_strap_lock: cover property (@(posedge clk) disable iff (!rst_n)
    s_reg.strap_locked && s_reg.strap_done);

endmodule // fet_ctrl

// ### rtl/fet_ctrl_pkg.sv
/*
  Types for the FET control block.
  Assumes the constants header is included by the design file.
*/
package fet_ctrl_pkg;

  // Diode emulation state, numbered as the state machine boxes
  typedef enum logic [1:0] {
    IDM_OFF   = 2'b00,  // Normal switching, no emulation
    IDM_BLANK = 2'b01,  // State 1
    IDM_WATCH = 2'b10,  // State 2
    IDM_COND  = 2'b11   // State 3
  } idm_state_t;

  // Analog sense inputs, already comparator levels
  typedef struct packed {
    logic       drain_neg;     // Drain voltage negative
    logic       curr_q1;       // First-quadrant drain current
    logic       fet_hot;       // FET overheat, hysteresis in comparator
    logic       drv_hot;       // Driver overheat, higher threshold
    logic [7:0] temp_c;        // Die temperature code
  } sense_t;

  // Complete state of the block
  typedef struct packed {
    idm_state_t idm;
    logic       gate_d;        // Delayed gate command for edges
    logic [7:0] blank_cnt;
    logic [15:0] pwm_cnt;
    logic [15:0] duty_cyc;     // Latched high time in cycles
    logic       temp_out;
    logic       fault_n;
    logic       fet_on;
    logic       strap_done;    // Strap test finished
    logic       strap_locked;  // Regulator strap found
    logic [2:0] slew;
    logic [2:0] slew_cand;     // Code under filtering
    logic [12:0] filt_cnt;
  } state_t;

endpackage

// ### rtl/fet_ctrl_regs.svh
/*
  Timing counts, code widths and duty figures for the FET control block.
  Assumes a 200 MHz clock and an 8-bit temperature code from the sensor front end.
*/
`ifndef FET_CTRL_REGS_SVH
`define FET_CTRL_REGS_SVH

`define CLK_MHZ            200
`define PWM_FREQ_HZ        9000
// Cycles per PWM period, rounded down from the 9 kHz rate
`define PWM_PERIOD_CYC     (`CLK_MHZ * 1000000 / `PWM_FREQ_HZ)
// Blanking after a gate command falling edge, in ns
`define BLANK_NS           200
`define BLANK_CYC          ((`BLANK_NS * `CLK_MHZ + 999) / 1000)
// Duty in permille
`define DUTY_FLOOR_PM      10
`define DUTY_LOW_PM        30
`define DUTY_HIGH_PM       820
// Temperature code is degrees Celsius, 0..255
`define TEMP_LOW_C         25
`define TEMP_HIGH_C        150
// Slew codes: 0 = 20 V/ns ... 7 = 150 V/ns
`define SLEW_CODE_FAST     3'h7
`define SLEW_CODE_100      3'h5
// Select pin decode classes
`define SEL_GND            2'h0
`define SEL_RES            2'h1
`define SEL_REG            2'h2
// Noise filter length on the select pin, in cycles
`define SEL_FILT_CYC       4096

`endif

// ### tb/fet_ctrl_partner.sv
/*
  Converter controller model: drives the gate command, reads the temperature PWM.
  Assumes callers enter its tasks just after a rising clk edge.
*/
`timescale 1ns/1ps
module fet_ctrl_partner #(
  parameter int PERIOD = 200  // PWM period in clk cycles
) (
  input  wire logic clk,
  input  wire logic temp_out,
  output logic      gate_cmd
);
  initial gate_cmd = 1'b0;  // Idle low until switching starts

  // New gate level, held past the sampling edge
  task automatic set_gate(input logic v);
    gate_cmd <= v;
    @(posedge clk);
  endtask

  // One toggle first, so an overheated device passes through blanking
  task automatic start_switching();
    set_gate(1'b1);
    set_gate(1'b0);
  endtask

  // High cycles and rising edges over two periods; any start phase works
  task automatic measure(output int hi, output int rises);
    logic last;
    hi = 0;
    rises = 0;
    last = temp_out;
    repeat (2 * PERIOD) begin
      @(negedge clk);
      if (temp_out === 1'b1) hi++;
      if (temp_out === 1'b1 && last === 1'b0) rises++;
      last = temp_out;
    end
    @(posedge clk);
  endtask

  // Duty fraction to junction temperature in degrees
  function automatic real to_temp(input int hi);
    return 162.3 * hi / (2.0 * PERIOD) + 20.1;
  endfunction
endmodule // fet_ctrl_partner

// ### tb/gan_driver_overheat_idm_control_tb_top.sv
/*
  Bench for the FET control block: slew select, temperature PWM, diode emulation.
  Assumes the design files and the partner model are compiled first.
*/
`timescale 1ns/1ps
module gan_driver_overheat_idm_control_tb_top;
  localparam int PER  = 200;  // Short PWM period keeps the run brief
  localparam int FILT = 16;   // Short select filter
  logic                 clk;
  logic                 nrst;          // Reset, active low
  logic                 gate_cmd;      // From the partner
  fet_ctrl_pkg::sense_t sense;         // Comparator levels
  logic [1:0]           sel_class;
  logic [2:0]           sel_res_code;
  logic                 fet_on;
  logic                 temp_out;
  logic                 fault_n;
  logic [2:0]           slew_code;
  int                   n_errors;
  int                   num_checks;
  int                   cycles = 0;    // Hang guard
  int                   hi;
  int                   rises;

  fet_ctrl #(.PWM_PERIOD(PER), .SEL_FILT(FILT)) dut (.clk(clk), .nrst(nrst),
    .gate_cmd(gate_cmd), .sense(sense), .sel_class(sel_class), .sel_res_code(sel_res_code),
    .fet_on(fet_on), .temp_out(temp_out), .fault_n(fault_n), .slew_code(slew_code));
  fet_ctrl_partner #(.PERIOD(PER)) partner (.clk(clk), .temp_out(temp_out),
    .gate_cmd(gate_cmd));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cut a hang short, well past the expected length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Reset held two cycles with the strap class already in place
  task automatic do_reset(input logic [1:0] cls);
    nrst <= 1'b0;
    sel_class <= cls;
    sel_res_code <= 3'h3;
    sense <= '0;
    partner.set_gate(1'b0);
    step(1);
    nrst <= 1'b1;
    step(6);
    @(negedge clk);
  endtask

  task automatic test_strap();
    do_reset(2'h2);
    check("slew strap", 16'(slew_code), 16'h5);
    step(1);
    sel_class <= 2'h0;
    step(FILT + 8);
    @(negedge clk);
    check("slew locked", 16'(slew_code), 16'h5);
    $display("test strap done");
  endtask

  task automatic test_slew();
    do_reset(2'h0);
    step(FILT + 4);
    @(negedge clk);
    check("slew ground", 16'(slew_code), 16'h7);
    for (int c = 0; c < 8; c++) begin
      step(1);
      sel_class <= 2'h1;
      sel_res_code <= 3'(c);
      step(FILT + 4);
      @(negedge clk);
      check("slew resistor", 16'(slew_code), 16'(c));
    end
    step(1);
    sel_res_code <= 3'h2;
    step(FILT / 2);
    @(negedge clk);
    check("slew filtered", 16'(slew_code), 16'h7);
    $display("test slew done");
  endtask

  task automatic test_pwm();
    logic [7:0] temps [4] = '{8'h0a, 8'h19, 8'h55, 8'h96};
    int         exp;
    foreach (temps[i]) begin
      step(1);
      sense.temp_c <= temps[i];
      step(2 * PER);
      partner.measure(hi, rises);
      exp = temps[i] < 25 ? 10 : 30 + (int'(temps[i]) - 25) * 790 / 125;
      exp = exp * 2 * PER / 1000;
      check("pwm high", 16'(hi >= exp - 2 && hi <= exp + 2), 16'h1);
      check("pwm edges", 16'(rises), 16'h2);
      if (temps[i] >= 25)
        check("pwm temp", 16'((partner.to_temp(hi) - temps[i] <= 6.0)
          && (partner.to_temp(hi) - temps[i] >= -6.0)), 16'h1);
    end
    sense.temp_c <= 8'hc8;
    step(2 * PER);
    partner.measure(hi, rises);
    check("pwm above span", 16'(hi > 332), 16'h1);
    $display("test pwm done");
  endtask

  task automatic test_gate(input logic g, input int n, input logic exp);
    partner.set_gate(g);
    step(n);
    @(negedge clk);
    check("fet on", 16'(fet_on), 16'(exp));
    step(1);
  endtask

  task automatic test_idm();
    step(1);
    test_gate(1'b1, 1, 1'b1);
    check("fault idle", 16'(fault_n), 16'h1);
    test_gate(1'b0, 1, 1'b0);
    sense.fet_hot <= 1'b1;
    step(3);
    @(negedge clk);
    check("fault hot", 16'(fault_n), 16'h0);
    check("fet entry", 16'(fet_on), 16'h0);
    check("temp high", 16'(temp_out), 16'h1);
    repeat (2) begin
      step(1);
      sense.curr_q1 <= 1'b0;
      sense.drain_neg <= 1'b1;
      step(3);
      @(negedge clk);
      check("fet cond", 16'(fet_on), 16'h1);
      step(1);
      sense.drain_neg <= 1'b0;
      sense.curr_q1 <= 1'b1;
      step(3);
      @(negedge clk);
      check("fet block", 16'(fet_on), 16'h0);
    end
    step(1);
    test_gate(1'b1, 4, 1'b0);
    sense.drain_neg <= 1'b1;
    sense.curr_q1 <= 1'b0;
    step(4);
    test_gate(1'b0, 30, 1'b0);
    step(17);
    @(negedge clk);
    check("fet after blank", 16'(fet_on), 16'h1);
    step(1);
    partner.start_switching();
    sense.drv_hot <= 1'b1;
    step(45);
    @(negedge clk);
    check("fet driver hot", 16'(fet_on), 16'h0);
    step(1);
    sense.drv_hot <= 1'b0;
    step(6);
    @(negedge clk);
    check("fet resume", 16'(fet_on), 16'h1);
    step(1);
    sense.fet_hot <= 1'b0;
    sense.drain_neg <= 1'b0;
    step(3);
    @(negedge clk);
    check("fault clear", 16'(fault_n), 16'h1);
    step(1);
    partner.measure(hi, rises);
    check("pwm resume", 16'(rises), 16'h2);
    test_gate(1'b1, 1, 1'b1);
    $display("test idm done");
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    n_errors = 0;
    num_checks = 0;
    test_strap();
    test_slew();
    test_pwm();
    test_idm();
    report_and_stop();
  end
endmodule // gan_driver_overheat_idm_control_tb_top
